// >>> design/cre_pkg.sv
// Constants, register map and types for the rms and mean-absolute-value engine
package cre_pkg;
  // Data widths
  localparam int SAMPLE_W   = 24;
  localparam int RMS_W      = 24;
  localparam int MAV_W      = 20;
  localparam int SQ_W       = 48;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 8;
  // Channel counts and positions
  localparam int NUM_RMS    = 7;
  localparam int NUM_CUR    = 3;
  localparam int NUM_OFS    = 4;
  localparam int CH_NEUTRAL = 6;
  // Timing
  localparam int CLOCK_HZ        = 200_000_000;
  localparam int DSP_RATE_HZ     = 8_000;
  localparam int TICK_CYCLES_DEF = CLOCK_HZ / DSP_RATE_HZ;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_RMS_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OFS_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_MAV_BASE = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG   = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_THIRD_CONFIG_REGISTER  = 8'h44;
  localparam logic [ADDR_W-1:0] ADDR_RUN      = 8'h48;
  localparam logic [ADDR_W-1:0] ADDR_POWER    = 8'h4C;
  // Fields and reset values
  localparam int INTEGRATOR_ENABLE_BIT  = 0;
  localparam int NEUTRAL_SUM_SELECT_BIT = 2;
  localparam int RUN_W                  = 16;
  localparam logic [RUN_W-1:0] RUN_START = 16'h0001;
  localparam logic [RUN_W-1:0] RUN_RESET = 16'h0000;
  localparam int OFS_ACC_W    = 28;
  localparam int OFFSET_SHIFT = 7;
  localparam int SQRT_ITER    = 24;
  localparam int MAV_OUT_SHIFT = 4;
  localparam logic [RMS_W-1:0] RMS_MAX = 24'h7FFFFF;
  localparam logic [MAV_W-1:0] MAV_MAX = 20'hFFFFF;
  // Power modes
  typedef enum logic [1:0] {
    PM_FULL    = 2'h0,
    PM_REDUCED = 2'h1,
    PM_LOW     = 2'h2,
    PM_SLEEP   = 2'h3
  } cre_power_t;
  // Square-root sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_ITER,
    ST_STORE
  } cre_state_t;
endpackage

// >>> design/cre_engine.sv
// Rms and mean-absolute-value engine with its register port
//
// Overview of operation
// - Rms only in full power; mav in full and reduced power
// - Square, low-pass filter, then square root
// - Seven parallel rms channels, 24-bit results
// - Mav on three phase currents, 20-bit results
// - Sum-select bit picks neutral or current sum
// - Current rms signed 24-bit, refreshed 8 kHz
// - Full-scale sine gives documented rms codes
// - Rms step settles within 580/700 ms
// - Small-signal settling about 1.3 s after run
// - Rms reads as 32 bits, top byte zero
// - Offset times 128 added before square root
// - Offset word: top nibble zero, 28-bit extended
// - Mav: high-pass, absolute, average at 8 kHz
// - No mav for the neutral channel
// - Full-scale sine gives documented mav codes
// - Mav settles within 500 ms
// - Mav reads as 32 bits, top twelve zero
// - Mav also runs in full power mode
// - Computation starts only after run written 0x0001
//
// Register map, byte addresses, word aligned
// Rms results 0x00-0x18: currents A-C, voltages A-C, neutral
// Offsets 0x20-0x2C: currents A-C, neutral
// Mean-absolute values 0x30-0x38: currents A-C
// Config 0x40: bit 0 integrator enable, stored only
// Third config 0x44: bit 2 neutral sum select
// Run word 0x48, power mode 0x4C
`timescale 1ns/1ps
`default_nettype none
module cre_engine
  import cre_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int LPF_SHIFT   = 10,
  parameter int HPF_SHIFT   = 12,
  parameter int MAV_SHIFT   = 10
) (
  input  wire logic                i_clock,
  input  wire logic                i_reset_n,
  input  wire logic [ADDR_W-1:0]   i_addr,
  input  wire logic [DATA_W-1:0]   i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  input  wire logic [SAMPLE_W-1:0] i_phase_a_current,
  input  wire logic [SAMPLE_W-1:0] i_phase_b_current,
  input  wire logic [SAMPLE_W-1:0] i_phase_c_current,
  input  wire logic [SAMPLE_W-1:0] i_phase_a_voltage,
  input  wire logic [SAMPLE_W-1:0] i_phase_b_voltage,
  input  wire logic [SAMPLE_W-1:0] i_phase_c_voltage,
  input  wire logic [SAMPLE_W-1:0] i_neutral_current,
  output logic      [DATA_W-1:0]   o_rdata
);

  // Internal widths with headroom for filter gain
  localparam int HPF_W = SAMPLE_W + HPF_SHIFT + 2;
  localparam int AVG_W = SAMPLE_W + MAV_SHIFT + 2;
  localparam int CNT_W = $clog2(TICK_CYCLES);
  localparam int ITR_W = $clog2(SQRT_ITER + 1);

  // Register file
  logic [RMS_W-1:0]  rms_reg [NUM_RMS];
  logic [RMS_W-1:0]  ofs_reg [NUM_OFS];
  logic [MAV_W-1:0]  mav_reg [NUM_CUR];
  logic              integrator_enable_reg;
  logic              neutral_sum_select_reg;
  logic [RUN_W-1:0]  run_reg;
  cre_power_t        power_mode_reg;
  logic [DATA_W-1:0] rdata_reg;

  // Frame timing and enables
  logic [CNT_W-1:0]  tick_cnt_reg;
  logic              tick;
  logic              running;
  logic              rms_enable;
  logic              mav_enable;

  // Samples and squared means
  logic signed [SAMPLE_W-1:0] samp [NUM_RMS];
  logic signed [SAMPLE_W+1:0] cur_sum;
  logic signed [SAMPLE_W-1:0] cur_sum_sat;
  logic [SQ_W-1:0]            mean_reg [NUM_RMS];

  // Square-root sequencer
  cre_state_t        state_reg;
  logic [2:0]        ch_reg;
  logic [ITR_W-1:0]  itr_reg;
  logic [SQ_W-1:0]   rad_reg;
  logic [RMS_W+1:0]  rem_reg;
  logic [RMS_W-1:0]  root_reg;
  logic signed [SQ_W:0] corr;
  logic signed [RMS_W-1:0] ofs_sel;
  logic [RMS_W+2:0]  rem_sh;
  logic [RMS_W+2:0]  trial;
  logic [RMS_W-1:0]  ofs_word_idx;

  // Bus decode
  logic [DATA_W-1:0] rdata_next;
  logic [ADDR_W-1:0] widx;

  // Compute only while run holds the start code
  assign running    = (run_reg == RUN_START);
  assign rms_enable = running && (power_mode_reg == PM_FULL);
  assign mav_enable = running && ((power_mode_reg == PM_FULL) ||
                                  (power_mode_reg == PM_REDUCED));
  assign tick       = running && (tick_cnt_reg == CNT_W'(TICK_CYCLES - 1));

  // DSP rate divider, cleared to zero while stopped
  // First tick one full frame after run starts
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_reg <= '0;
    end else if (!running || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // Instantaneous sum of the phase currents, saturated
  // Sum can pass 24 bits; clamp rather than wrap
  assign cur_sum = $signed(i_phase_a_current) + $signed(i_phase_b_current)
                 + $signed(i_phase_c_current);
  always_comb begin
    if (cur_sum > $signed(26'h07FFFFF)) begin
      cur_sum_sat = 24'h7FFFFF;
    end else if (cur_sum < $signed(26'h3800000)) begin
      cur_sum_sat = 24'h800000;
    end else begin
      cur_sum_sat = cur_sum[SAMPLE_W-1:0];
    end
  end

  // Channel order: three currents, three voltages, neutral
  // Neutral slot carries the phase sum when selected
  assign samp[0] = i_phase_a_current;
  assign samp[1] = i_phase_b_current;
  assign samp[2] = i_phase_c_current;
  assign samp[3] = i_phase_a_voltage;
  assign samp[4] = i_phase_b_voltage;
  assign samp[5] = i_phase_c_voltage;
  assign samp[CH_NEUTRAL] = neutral_sum_select_reg ? cur_sum_sat
                                                   : $signed(i_neutral_current);

  // Square and low-pass filter, one per channel in parallel
  genvar g;
  generate
    for (g = 0; g < NUM_RMS; g++) begin : g_sq
      logic signed [SQ_W-1:0] sq;
      logic signed [SQ_W:0]   diff;
      logic signed [SQ_W:0]   step;
      // Square and first-order low-pass step
      assign sq   = samp[g] * samp[g];
      assign diff = $signed({1'b0, sq}) - $signed({1'b0, mean_reg[g]});
      assign step = diff >>> LPF_SHIFT;
      // Mean of the squared stream
      // Starts from zero, so settling counts from run
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          mean_reg[g] <= '0;
        end else if (tick && rms_enable) begin
          mean_reg[g] <= mean_reg[g] + step[SQ_W-1:0];
        end
      end
    end
  endgenerate

  // High-pass, absolute value and average on phase currents only
  generate
    for (g = 0; g < NUM_CUR; g++) begin : g_mav
      logic signed [HPF_W-1:0]    dc_acc_reg;
      logic signed [SAMPLE_W:0]   hp;
      logic [SAMPLE_W:0]          absv;
      logic [AVG_W-1:0]           avg_acc_reg;
      logic [AVG_W-1:0]           avg;
      logic [AVG_W-1:0]           scaled;
      // High-pass: subtract the running dc estimate
      assign hp     = (SAMPLE_W+1)'(samp[g] - (dc_acc_reg >>> HPF_SHIFT));
      assign absv   = hp[SAMPLE_W] ? (SAMPLE_W+1)'(-hp) : hp;
      assign avg    = avg_acc_reg >> MAV_SHIFT;
      assign scaled = avg >> MAV_OUT_SHIFT;
      // Dc estimate and averaging accumulators
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          dc_acc_reg  <= '0;
          avg_acc_reg <= '0;
        end else if (tick && mav_enable) begin
          dc_acc_reg  <= dc_acc_reg + HPF_W'(samp[g])
                       - (dc_acc_reg >>> HPF_SHIFT);
          avg_acc_reg <= avg_acc_reg + AVG_W'(absv) - avg;
        end
      end
      // Unsigned 20-bit result, refreshed each frame in full and reduced power
      // Reads pre-update accumulator: one frame of lag
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          mav_reg[g] <= '0;
        end else if (tick && mav_enable) begin
          mav_reg[g] <= (scaled > AVG_W'(MAV_MAX)) ? MAV_MAX
                                                   : scaled[MAV_W-1:0];
        end
      end
    end
  endgenerate

  // Offset for the selected channel; voltages carry none
  // Neutral offset applies in both sum states
  always_comb begin
    if (ch_reg < 3'(NUM_CUR)) begin
      ofs_sel = ofs_reg[ch_reg[1:0]];
    end else if (ch_reg == 3'(CH_NEUTRAL)) begin
      ofs_sel = ofs_reg[NUM_OFS-1];
    end else begin
      ofs_sel = '0;
    end
  end

  // Offset times 128 added to the mean square
  assign corr = $signed({1'b0, mean_reg[ch_reg]})
              + ((SQ_W+1)'(ofs_sel) <<< OFFSET_SHIFT);

  // One bit of the square root per cycle
  // Restoring root, two radicand bits per step
  assign rem_sh = {rem_reg[RMS_W:0], rad_reg[SQ_W-1 -: 2]};
  assign trial  = {1'b0, root_reg, 2'b01};

  // Sequencer: walks the seven channels once per frame in full power
  // 26 cycles per channel: frame must exceed 182
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
      ch_reg    <= '0;
      itr_reg   <= '0;
      rad_reg   <= '0;
      rem_reg   <= '0;
      root_reg  <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          ch_reg <= '0;
          if (tick && rms_enable) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          rad_reg   <= corr[SQ_W] ? '0 : corr[SQ_W-1:0];
          rem_reg   <= '0;
          root_reg  <= '0;
          itr_reg   <= '0;
          state_reg <= ST_ITER;
        end
        ST_ITER: begin
          rad_reg <= rad_reg << 2;
          if (rem_sh >= trial) begin
            rem_reg  <= (RMS_W+2)'(rem_sh - trial);
            root_reg <= {root_reg[RMS_W-2:0], 1'b1};
          end else begin
            rem_reg  <= rem_sh[RMS_W+1:0];
            root_reg <= {root_reg[RMS_W-2:0], 1'b0};
          end
          itr_reg <= itr_reg + 1'b1;
          if (itr_reg == ITR_W'(SQRT_ITER - 1)) begin
            state_reg <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (ch_reg == 3'(NUM_RMS - 1)) begin
            state_reg <= ST_IDLE;
          end else begin
            ch_reg    <= ch_reg + 1'b1;
            state_reg <= ST_LOAD;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Rms results, signed 24-bit, saturated positive
  // Never negative, so the sign bit stays clear
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < NUM_RMS; k++) begin
        rms_reg[k] <= '0;
      end
    end else if (state_reg == ST_STORE) begin
      rms_reg[ch_reg] <= root_reg[RMS_W-1] ? RMS_MAX : root_reg;
    end
  end

  // Word index of a bus address
  assign widx         = {2'b00, i_addr[ADDR_W-1:2]};
  assign ofs_word_idx = RMS_W'(widx - {2'b00, ADDR_OFS_BASE[ADDR_W-1:2]});

  // Software-written control and calibration registers
  // Unaligned or read-only addresses are ignored
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < NUM_OFS; k++) begin
        ofs_reg[k] <= '0;
      end
      integrator_enable_reg  <= 1'b0;
      neutral_sum_select_reg <= 1'b0;
      run_reg                <= RUN_RESET;
      power_mode_reg         <= PM_FULL;
    end else if (i_wr && (i_addr[1:0] == 2'b00)) begin
      if ((i_addr >= ADDR_OFS_BASE) && (i_addr < ADDR_OFS_BASE + 8'(4 * NUM_OFS))) begin
        ofs_reg[ofs_word_idx[1:0]] <= i_wdata[RMS_W-1:0];
      end else if (i_addr == ADDR_CONFIG) begin
        integrator_enable_reg <= i_wdata[INTEGRATOR_ENABLE_BIT];
      end else if (i_addr == ADDR_THIRD_CONFIG_REGISTER) begin
        neutral_sum_select_reg <= i_wdata[NEUTRAL_SUM_SELECT_BIT];
      end else if (i_addr == ADDR_RUN) begin
        run_reg <= i_wdata[RUN_W-1:0];
      end else if (i_addr == ADDR_POWER) begin
        power_mode_reg <= cre_power_t'(i_wdata[1:0]);
      end
    end
  end

  // Read decode with zero padding above each field
  // Offsets read back sign-extended to 28 bits
  always_comb begin
    logic [ADDR_W-1:0] ri;
    ri         = '0;
    rdata_next = '0;
    if (i_addr[1:0] != 2'b00) begin
      rdata_next = '0;
    end else if ((i_addr >= ADDR_RMS_BASE) &&
                 (i_addr < ADDR_RMS_BASE + 8'(4 * NUM_RMS))) begin
      ri         = widx - {2'b00, ADDR_RMS_BASE[ADDR_W-1:2]};
      rdata_next = {8'h00, rms_reg[ri[2:0]]};
    end else if ((i_addr >= ADDR_OFS_BASE) &&
                 (i_addr < ADDR_OFS_BASE + 8'(4 * NUM_OFS))) begin
      ri         = widx - {2'b00, ADDR_OFS_BASE[ADDR_W-1:2]};
      rdata_next = {4'h0, {(OFS_ACC_W-RMS_W){ofs_reg[ri[1:0]][RMS_W-1]}},
                    ofs_reg[ri[1:0]]};
    end else if ((i_addr >= ADDR_MAV_BASE) &&
                 (i_addr < ADDR_MAV_BASE + 8'(4 * NUM_CUR))) begin
      ri         = widx - {2'b00, ADDR_MAV_BASE[ADDR_W-1:2]};
      rdata_next = {12'h000, mav_reg[ri[1:0]]};
    end else if (i_addr == ADDR_CONFIG) begin
      rdata_next[INTEGRATOR_ENABLE_BIT] = integrator_enable_reg;
    end else if (i_addr == ADDR_THIRD_CONFIG_REGISTER) begin
      rdata_next[NEUTRAL_SUM_SELECT_BIT] = neutral_sum_select_reg;
    end else if (i_addr == ADDR_RUN) begin
      rdata_next = {16'h0000, run_reg};
    end else if (i_addr == ADDR_POWER) begin
      rdata_next = {30'h0, power_mode_reg};
    end
  end

  // Read data stands for one cycle after the strobe
  // Cleared otherwise so no stale word lingers
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= '0;
    end else if (i_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  // Output straight from the read flop
  assign o_rdata = rdata_reg;

endmodule
`default_nettype wire

// >>> verif/cre_engine_checker.sv
// Port-level checks of the rms engine
`timescale 1ns/1ps
`default_nettype none
module cre_engine_checker
  import cre_pkg::*;
(
  input wire logic              i_clock,
  input wire logic              i_reset_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata
);
  logic ran_reg;
  wire  rms_a = i_addr <= 8'h18;
  wire  mav_a = i_addr inside {8'h30, 8'h34, 8'h38};
  // Set once the run word starts the engine
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n)
      ran_reg <= 1'b0;
    else if (i_wr && i_addr == ADDR_RUN && i_wdata[15:0] == RUN_START)
      ran_reg <= 1'b1;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Offset write, one idle cycle, then read back
  sequence s_ofs_wr; i_wr && i_addr == ADDR_OFS_BASE; endsequence
  sequence s_ofs_rd; i_rd && i_addr == ADDR_OFS_BASE; endsequence
  property p_idle; !i_rd |=> o_rdata == '0; endproperty
  property p_rms_pad; i_rd && rms_a |=> o_rdata[31:23] == '0; endproperty
  property p_mav_pad; i_rd && mav_a |=> o_rdata[31:20] == '0; endproperty
  property p_ofs_ext;
    i_rd && i_addr inside {8'h20, 8'h24, 8'h28, 8'h2C}
      |=> o_rdata[31:28] == '0 && o_rdata[27:24] == {4{o_rdata[23]}};
  endproperty
  property p_ofs_keep;
    s_ofs_wr ##2 s_ofs_rd |=> o_rdata[23:0] == $past(i_wdata[23:0], 3);
  endproperty
  property p_norun; !ran_reg && i_rd && (rms_a || mav_a) |=> o_rdata == '0; endproperty
  property p_unal; i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == '0; endproperty
  property p_no_nmav; i_rd && i_addr == 8'h3C |=> o_rdata == '0; endproperty
  a_idle: assert property (p_idle) else $error("data outside a read");
  a_rms_pad: assert property (p_rms_pad) else $error("rms padding");
  a_mav_pad: assert property (p_mav_pad) else $error("mav padding");
  a_ofs_ext: assert property (p_ofs_ext) else $error("offset extension");
  a_ofs_keep: assert property (p_ofs_keep) else $error("offset lost");
  a_norun: assert property (p_norun) else $error("result before run");
  a_unal: assert property (p_unal) else $error("unaligned read data");
  a_no_nmav: assert property (p_no_nmav) else $error("neutral mav seen");
endmodule
bind cre_engine cre_engine_checker cre_engine_checker_i (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata)
);
`default_nettype wire

// >>> verif/cre_engine_test.sv
// Self-checking bench of the rms engine
`timescale 1ns/1ps
`default_nettype none
module cre_engine_test
  import cre_pkg::*;
;
  localparam int TK = 200;
  logic                i_clock = 1'b0;
  logic                i_reset_n = 1'b0;
  logic                i_wr = 1'b0;
  logic                i_rd = 1'b0;
  logic [ADDR_W-1:0]   i_addr = '0;
  logic [DATA_W-1:0]   i_wdata = '0;
  logic [DATA_W-1:0]   o_rdata;
  logic [SAMPLE_W-1:0] smp [7] = '{default: '0};
  logic [RMS_W-1:0]    rms_e [7] = '{default: '0};
  logic [MAV_W-1:0]    mav_e [3] = '{default: '0};
  logic [RMS_W-1:0]    ofs [4] = '{default: '0};
  longint              mean [7] = '{default: 0};
  longint              dc [3] = '{default: 0};
  longint              av [3] = '{default: 0};
  logic [1:0]          pm = 2'h0;
  logic                sel = 1'b0;
  int                  err_count = 0;
  int                  total_checks = 0;
  int                  cyc = 0;
  // Engine with short frame and filter constants
  cre_engine #(.TICK_CYCLES(TK), .LPF_SHIFT(2), .HPF_SHIFT(3), .MAV_SHIFT(2)) cre_engine_i (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_phase_a_current(smp[0]), .i_phase_b_current(smp[1]),
    .i_phase_c_current(smp[2]), .i_phase_a_voltage(smp[3]), .i_phase_b_voltage(smp[4]),
    .i_phase_c_voltage(smp[5]), .i_neutral_current(smp[6]), .o_rdata(o_rdata)
  );
  // Clock and hang guard
  always #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 40 * TK) begin
      err_count++;
      end_of_test();
    end
  end
  function automatic longint sx(logic [SAMPLE_W-1:0] v);
    return longint'(signed'(v));
  endfunction
  function automatic longint isqrt(longint r);
    longint q = 0;
    for (int b = 23; b >= 0; b--)
      if ((q + (64'sh1 <<< b)) * (q + (64'sh1 <<< b)) <= r)
        q += 64'sh1 <<< b;
    return q;
  endfunction
  // One frame tick of the reference model
  task automatic step();
    longint x, r;
    for (int k = 0; k < 3; k++)
      if (pm < 2'h2) begin
        x = sx(smp[k]) - (dc[k] >>> 3);
        mav_e[k] = ((av[k] >> 6) > MAV_MAX) ? MAV_MAX : MAV_W'(av[k] >> 6);
        dc[k] += x;
        av[k] += (x < 0 ? -x : x) - (av[k] >> 2);
      end
    if (pm == 2'h0)
      for (int k = 0; k < 7; k++) begin
        x = (k == 6 && sel) ? sx(smp[0]) + sx(smp[1]) + sx(smp[2]) : sx(smp[k]);
        mean[k] += (x * x - mean[k]) >>> 2;
        r = mean[k] + 64'sh80 * (k < 3 ? sx(ofs[k]) : k == 6 ? sx(ofs[3]) : 64'sh0);
        r = isqrt(r < 0 ? 64'sh0 : r);
        rms_e[k] = (r > RMS_MAX) ? RMS_MAX : RMS_W'(r);
      end
  endtask
  task automatic check_val(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // Register bus master, one idle cycle after each access
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 check_val(o_rdata, e);
    @(posedge i_clock);
  endtask
  // New samples; phase A stays small against its offset
  task automatic nxt();
    for (int k = 0; k < 7; k++)
      smp[k] <= (k == 0) ? 24'($urandom_range(24'h7D0)) - 24'h3E8
                         : 24'($urandom_range(24'h1FFFFF)) - 24'h100000;
  endtask
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [RMS_W-1:0] v;
    void'($urandom(32'hDC1C5D16));
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    nxt();
    for (int a = 0; a < 8'h40; a += 4) rd(8'(a), 32'h0);
    rd(8'h02, 32'h0);
    wr(ADDR_RMS_BASE, 32'($urandom));
    rd(ADDR_RMS_BASE, 32'h0);
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 24'h800000 : 24'($urandom);
      ofs[k] = v;
      wr(ADDR_OFS_BASE + 8'(4 * k), {8'($urandom), v});
      rd(ADDR_OFS_BASE + 8'(4 * k), {4'h0, {4{v[23]}}, v});
    end
    wr(ADDR_CONFIG, 32'h1);
    rd(ADDR_CONFIG, 32'h1);
    wr(ADDR_RUN, {16'h0, RUN_START});
    step();
    repeat (2 * TK - 17) @(posedge i_clock);
    // Frames with neutral source and power mode stepping
    for (int f = 0; f < 24; f++) begin
      nxt();
      for (int k = 0; k < 3; k++)
        rd(ADDR_MAV_BASE + 8'(4 * k), {12'h0, mav_e[k]});
      for (int k = 0; k < 7; k++)
        rd(ADDR_RMS_BASE + 8'(4 * k), {8'h0, rms_e[k]});
      step();
      sel = f >= 5 && f < 10;
      pm = (f < 11 || f > 18) ? 2'h0 : (f < 15) ? 2'h1 : (f < 17) ? 2'h2 : 2'h3;
      wr(ADDR_THIRD_CONFIG_REGISTER, 32'(sel) << NEUTRAL_SUM_SELECT_BIT);
      wr(ADDR_POWER, {30'h0, pm});
      repeat (TK - 24) @(posedge i_clock);
    end
    // Control readback, then a stopped engine keeps its results
    rd(ADDR_RUN, {16'h0, RUN_START});
    rd(ADDR_POWER, {30'h0, pm});
    rd(ADDR_THIRD_CONFIG_REGISTER, 32'(sel) << NEUTRAL_SUM_SELECT_BIT);
    wr(ADDR_RUN, 32'h0);
    nxt();
    repeat (2 * TK) @(posedge i_clock);
    for (int k = 0; k < 3; k++)
      rd(ADDR_MAV_BASE + 8'(4 * k), {12'h0, mav_e[k]});
    for (int k = 0; k < 7; k++)
      rd(ADDR_RMS_BASE + 8'(4 * k), {8'h0, rms_e[k]});
    end_of_test();
  end
endmodule
`default_nettype wire
